// ### hdl/sync_serial_pkg.sv
`default_nettype none

package sync_serial_pkg;

  // Byte addresses of the registers on the bus.
  localparam logic [4:0] ADDR_TX_STATUS_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_RX_STATUS_CONTROL = 5'h04;
  localparam logic [4:0] ADDR_TX_HOLDING_DATA = 5'h08;
  localparam logic [4:0] ADDR_RX_DATA_FIFO_TOP = 5'h0C;
  localparam logic [4:0] ADDR_CLOCK_POLARITY_BAUD = 5'h10;
  localparam logic [4:0] ADDR_BAUD_DIVISOR_LOW = 5'h14;
  localparam logic [4:0] ADDR_BAUD_DIVISOR_HIGH = 5'h18;
  localparam logic [4:0] ADDR_INTERRUPT_CONTROL = 5'h1C;

  // Transmit status and control fields.
  localparam int TXS_CLOCK_SOURCE_MASTER = 7;
  localparam int TXS_NINE_BIT_TRANSMIT = 6;
  localparam int TXS_TRANSMIT_ENABLE = 5;
  localparam int TXS_SYNC_MODE = 4;
  localparam int TXS_SHIFTER_EMPTY = 1;
  localparam int TXS_TRANSMIT_NINTH_BIT = 0;
  localparam logic [7:0] TXS_WRITE_MASK = 8'hFD;

  // Receive status and control fields.
  localparam int RXS_PORT_ENABLE = 7;
  localparam int RXS_NINE_BIT_RECEIVE = 6;
  localparam int RXS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RXS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RXS_OVERRUN_ERROR_FLAG = 1;
  localparam int RXS_RECEIVE_NINTH_BIT = 0;
  localparam logic [7:0] RXS_WRITE_MASK = 8'hF8;

  // Clock polarity and baud control fields.
  localparam int BDC_RECEIVER_IDLE = 6;
  localparam int BDC_CLOCK_POLARITY_SELECT = 4;
  localparam logic [7:0] BDC_WRITE_MASK = 8'h1B;

  // Interrupt control fields.
  localparam int INT_GLOBAL_ENABLE = 7;
  localparam int INT_PERIPHERAL_ENABLE = 6;
  localparam int INT_RECEIVE_ENABLE = 5;
  localparam int INT_TRANSMIT_ENABLE = 4;
  localparam int INT_RECEIVE_COMPLETE_FLAG = 1;
  localparam int INT_TRANSMIT_BUFFER_EMPTY_FLAG = 0;
  localparam logic [7:0] INT_WRITE_MASK = 8'hF0;

  // Values after reset, character lengths and the receive FIFO depth.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam int CHAR_WIDTH = 9;
  localparam int FIFO_DEPTH = 2;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

endpackage : sync_serial_pkg

`default_nettype wire

// ### hdl/pin_sync_edge.sv
`default_nettype none

module pin_sync_edge (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Two stages bring the pin into the clock domain, a third finds its edges.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (ce_i) begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Edge strobes look only at the settled stages.
  assign level_o = sync_ff;
  assign rise_o = ce_i & sync_ff & ~last_ff;
  assign fall_o = ce_i & ~sync_ff & last_ff;

endmodule : pin_sync_edge

`default_nettype wire

// ### hdl/rx_char_fifo.sv
`default_nettype none

module rx_char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] top_o,
  output logic empty_o,
  output logic full_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] rd_ptr_ff;
  logic [PW-1:0] wr_ptr_ff;
  logic [PW:0] count_ff;
  logic do_push;
  logic do_pop;

  assign empty_o = (count_ff == '0);
  assign full_o = (count_ff == (PW + 1)'(DEPTH));
  assign do_push = push_i & ~full_o;
  assign do_pop = pop_i & ~empty_o;
  assign top_o = mem_ff[rd_ptr_ff];

  // Pointers wrap at the depth; push and pop may happen in one cycle.
  always_ff @(posedge mclk_i) begin
    if (reset_i || (ce_i && clear_i)) begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      count_ff <= '0;
    end else if (ce_i) begin
      if (do_push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
    end
  end

  // Storage entries, one per slot.
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        mem_ff[i] <= '0;
      end else if (ce_i && do_push && (wr_ptr_ff == PW'(i))) begin
        mem_ff[i] <= push_data_i;
      end
    end
  end

endmodule : rx_char_fifo

`default_nettype wire

// ### hdl/sync_serial_slave_port.sv
`default_nettype none

module sync_serial_slave_port (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sleep_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe_n_o,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_n_o,
  output logic wake_o,
  output logic irq_o,
  output logic rx_int_o
);

  // Software-visible storage.
  logic [7:0] tx_status_control_ff;
  logic [7:0] rx_status_control_ff;
  logic [7:0] clock_polarity_baud_ff;
  logic [7:0] baud_divisor_low_ff;
  logic [7:0] baud_divisor_high_ff;
  logic [7:0] interrupt_control_ff;

  // Bus handshake.
  logic ack_ff;
  logic [31:0] readdata_ff;
  logic bus_req;
  logic wr_en;
  logic rd_pop;
  logic [7:0] nxt_readdata;

  // Transmit path.
  logic [7:0] transmit_holding_data_ff;
  logic hold_valid_ff;
  sync_serial_pkg::tx_state_t tx_state_ff;
  logic [8:0] transmit_shift_register_ff;
  logic [3:0] tx_cnt_ff;
  logic [3:0] tx_len_ff;
  logic dout_ff;
  logic data_oe_n_ff;
  logic tx_load;
  logic tx_done;

  // Receive path.
  logic [8:0] receive_shift_register_ff;
  logic [3:0] rx_cnt_ff;
  logic overrun_error_flag_ff;
  logic [8:0] nxt_rsr;
  logic [8:0] rx_char;
  logic [3:0] rx_len;
  logic rx_done;
  logic fifo_push;
  logic [8:0] fifo_top;
  logic fifo_empty;
  logic fifo_full;

  // Mode decode and pin edges.
  logic port_enable;
  logic slave_mode;
  logic tx_mode;
  logic rx_active;
  logic ck_rise;
  logic ck_fall;
  logic data_level;
  logic lead_edge;
  logic trail_edge;
  logic transmit_buffer_empty_flag;
  logic receive_complete_flag;
  logic tx_event;
  logic rx_event;

  // The shift clock and the data pin are both brought into this domain with equal delay.
  pin_sync_edge u_clock_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .pin_i(shift_clock_pin_i),
    .level_o(),
    .rise_o(ck_rise),
    .fall_o(ck_fall)
  );

  pin_sync_edge u_data_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .pin_i(serial_data_pin_i),
    .level_o(data_level),
    .rise_o(),
    .fall_o()
  );

  // Operating mode follows the control bits.
  assign port_enable = rx_status_control_ff[sync_serial_pkg::RXS_PORT_ENABLE];
  assign slave_mode = tx_status_control_ff[sync_serial_pkg::TXS_SYNC_MODE]
    & ~tx_status_control_ff[sync_serial_pkg::TXS_CLOCK_SOURCE_MASTER];
  assign tx_mode = port_enable & slave_mode
    & ~rx_status_control_ff[sync_serial_pkg::RXS_SINGLE_RECEIVE_ENABLE]
    & ~rx_status_control_ff[sync_serial_pkg::RXS_CONTINUOUS_RECEIVE_ENABLE]
    & tx_status_control_ff[sync_serial_pkg::TXS_TRANSMIT_ENABLE];
  // Receiving needs the port enable, slave mode and continuous receive; single receive is ignored here.
  assign rx_active = port_enable & slave_mode
    & rx_status_control_ff[sync_serial_pkg::RXS_CONTINUOUS_RECEIVE_ENABLE];

  // Polarity picks which pin edge leads; data changes on it and is sampled on the other.
  assign lead_edge = clock_polarity_baud_ff[sync_serial_pkg::BDC_CLOCK_POLARITY_SELECT] ? ck_fall : ck_rise;
  assign trail_edge = clock_polarity_baud_ff[sync_serial_pkg::BDC_CLOCK_POLARITY_SELECT] ? ck_rise : ck_fall;

  // The clock pin is never driven in slave mode.
  assign shift_clock_pin_o = 1'b0;
  assign shift_clock_pin_oe_n_o = 1'b1;
  assign serial_data_pin_o = dout_ff;
  assign serial_data_pin_oe_n_o = data_oe_n_ff;

  // One wait cycle per access; the access completes when waitrequest is low.
  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack_ff;
  assign avs_readdata_o = readdata_ff;
  assign wr_en = ce_i & avs_write_i & ack_ff & avs_byteenable_i[0];
  assign rd_pop = ce_i & avs_read_i & ack_ff & (avs_address_i == sync_serial_pkg::ADDR_RX_DATA_FIFO_TOP);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // Read multiplexer; status bits are overlaid on the stored control bits.
  always_comb begin
    nxt_readdata = sync_serial_pkg::REG_RESET;
    case (avs_address_i)
      sync_serial_pkg::ADDR_TX_STATUS_CONTROL: begin
        nxt_readdata = tx_status_control_ff;
        nxt_readdata[sync_serial_pkg::TXS_SHIFTER_EMPTY] = (tx_state_ff == sync_serial_pkg::TX_IDLE);
      end
      sync_serial_pkg::ADDR_RX_STATUS_CONTROL: begin
        nxt_readdata = rx_status_control_ff;
        nxt_readdata[sync_serial_pkg::RXS_OVERRUN_ERROR_FLAG] = overrun_error_flag_ff;
        nxt_readdata[sync_serial_pkg::RXS_RECEIVE_NINTH_BIT] = fifo_top[8];
      end
      sync_serial_pkg::ADDR_RX_DATA_FIFO_TOP: nxt_readdata = fifo_top[7:0];
      sync_serial_pkg::ADDR_CLOCK_POLARITY_BAUD: begin
        nxt_readdata = clock_polarity_baud_ff;
        nxt_readdata[sync_serial_pkg::BDC_RECEIVER_IDLE] = (rx_cnt_ff == 4'h0);
      end
      sync_serial_pkg::ADDR_BAUD_DIVISOR_LOW: nxt_readdata = baud_divisor_low_ff;
      sync_serial_pkg::ADDR_BAUD_DIVISOR_HIGH: nxt_readdata = baud_divisor_high_ff;
      sync_serial_pkg::ADDR_INTERRUPT_CONTROL: begin
        nxt_readdata = interrupt_control_ff;
        nxt_readdata[sync_serial_pkg::INT_RECEIVE_COMPLETE_FLAG] = receive_complete_flag;
        nxt_readdata[sync_serial_pkg::INT_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
      end
      default: nxt_readdata = sync_serial_pkg::REG_RESET;
    endcase
  end

  // Read data is captured in the wait cycle and stands through the completing edge.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      readdata_ff <= 32'h0000_0000;
    end else if (ce_i && avs_read_i && !ack_ff) begin
      readdata_ff <= {24'h00_0000, nxt_readdata};
    end
  end

  // Control registers; only writable bits are stored.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_status_control_ff <= sync_serial_pkg::REG_RESET;
      rx_status_control_ff <= sync_serial_pkg::REG_RESET;
      clock_polarity_baud_ff <= sync_serial_pkg::REG_RESET;
      baud_divisor_low_ff <= sync_serial_pkg::REG_RESET;
      baud_divisor_high_ff <= sync_serial_pkg::REG_RESET;
      interrupt_control_ff <= sync_serial_pkg::REG_RESET;
    end else if (wr_en) begin
      case (avs_address_i)
        sync_serial_pkg::ADDR_TX_STATUS_CONTROL:
          tx_status_control_ff <= avs_writedata_i[7:0] & sync_serial_pkg::TXS_WRITE_MASK;
        sync_serial_pkg::ADDR_RX_STATUS_CONTROL:
          rx_status_control_ff <= avs_writedata_i[7:0] & sync_serial_pkg::RXS_WRITE_MASK;
        sync_serial_pkg::ADDR_CLOCK_POLARITY_BAUD:
          clock_polarity_baud_ff <= avs_writedata_i[7:0] & sync_serial_pkg::BDC_WRITE_MASK;
        sync_serial_pkg::ADDR_BAUD_DIVISOR_LOW: baud_divisor_low_ff <= avs_writedata_i[7:0];
        sync_serial_pkg::ADDR_BAUD_DIVISOR_HIGH: baud_divisor_high_ff <= avs_writedata_i[7:0];
        sync_serial_pkg::ADDR_INTERRUPT_CONTROL:
          interrupt_control_ff <= avs_writedata_i[7:0] & sync_serial_pkg::INT_WRITE_MASK;
        default: ;
      endcase
    end
  end

  // Holding register: a write fills it, a move to the shifter empties it; the write wins.
  assign transmit_buffer_empty_flag = ~hold_valid_ff;
  assign tx_load = ce_i & tx_mode & hold_valid_ff & (tx_state_ff == sync_serial_pkg::TX_IDLE);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      transmit_holding_data_ff <= sync_serial_pkg::REG_RESET;
      hold_valid_ff <= 1'b0;
    end else if (ce_i) begin
      if (!port_enable) begin
        hold_valid_ff <= 1'b0;
      end else if (wr_en && avs_address_i == sync_serial_pkg::ADDR_TX_HOLDING_DATA) begin
        transmit_holding_data_ff <= avs_writedata_i[7:0];
        hold_valid_ff <= 1'b1;
      end else if (tx_load) begin
        hold_valid_ff <= 1'b0;
      end
    end
  end

  // The shifter ends a character after the trailing edge of its last bit.
  assign tx_done = (tx_state_ff == sync_serial_pkg::TX_SHIFT) & trail_edge & (tx_cnt_ff == tx_len_ff);

  // Transmit shifter: a bit goes out on each leading edge, least significant first.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_state_ff <= sync_serial_pkg::TX_IDLE;
      transmit_shift_register_ff <= 9'h000;
      tx_cnt_ff <= 4'h0;
      tx_len_ff <= sync_serial_pkg::BITS_EIGHT;
      dout_ff <= 1'b0;
    end else if (ce_i) begin
      case (tx_state_ff)
        sync_serial_pkg::TX_IDLE: begin
          if (tx_load) begin
            transmit_shift_register_ff <= {tx_status_control_ff[sync_serial_pkg::TXS_TRANSMIT_NINTH_BIT],
              transmit_holding_data_ff};
            tx_len_ff <= tx_status_control_ff[sync_serial_pkg::TXS_NINE_BIT_TRANSMIT] ?
              sync_serial_pkg::BITS_NINE : sync_serial_pkg::BITS_EIGHT;
            tx_cnt_ff <= 4'h0;
            tx_state_ff <= sync_serial_pkg::TX_SHIFT;
          end
        end
        sync_serial_pkg::TX_SHIFT: begin
          if (!tx_mode) begin
            tx_state_ff <= sync_serial_pkg::TX_IDLE;
          end else if (lead_edge && tx_cnt_ff != tx_len_ff) begin
            dout_ff <= transmit_shift_register_ff[0];
            transmit_shift_register_ff <= {1'b0, transmit_shift_register_ff[8:1]};
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
          end else if (tx_done) begin
            tx_state_ff <= sync_serial_pkg::TX_IDLE;
          end
        end
        default: tx_state_ff <= sync_serial_pkg::TX_IDLE;
      endcase
    end
  end

  // The data pin is driven only while slave transmission is selected.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      data_oe_n_ff <= 1'b1;
    end else if (ce_i) begin
      data_oe_n_ff <= ~tx_mode;
    end
  end

  // Receive shifter samples on trailing edges and assembles least significant bit first.
  assign rx_len = rx_status_control_ff[sync_serial_pkg::RXS_NINE_BIT_RECEIVE] ?
    sync_serial_pkg::BITS_NINE : sync_serial_pkg::BITS_EIGHT;
  assign nxt_rsr = {data_level, receive_shift_register_ff[8:1]};
  assign rx_char = rx_status_control_ff[sync_serial_pkg::RXS_NINE_BIT_RECEIVE] ?
    nxt_rsr : {1'b0, nxt_rsr[8:1]};
  assign rx_done = rx_active & trail_edge & ~overrun_error_flag_ff & (rx_cnt_ff == rx_len - 4'h1);
  assign fifo_push = rx_done & ~fifo_full;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      receive_shift_register_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
    end else if (ce_i) begin
      if (!rx_active) begin
        rx_cnt_ff <= 4'h0;
      end else if (trail_edge && !overrun_error_flag_ff) begin
        receive_shift_register_ff <= nxt_rsr;
        rx_cnt_ff <= rx_done ? 4'h0 : rx_cnt_ff + 4'h1;
      end
    end
  end

  // Overrun sets on a third complete character and blocks reception until cleared.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      overrun_error_flag_ff <= 1'b0;
    end else if (ce_i) begin
      if (!port_enable || !rx_status_control_ff[sync_serial_pkg::RXS_CONTINUOUS_RECEIVE_ENABLE]) begin
        overrun_error_flag_ff <= 1'b0;
      end else if (rx_done && fifo_full) begin
        overrun_error_flag_ff <= 1'b1;
      end
    end
  end

  rx_char_fifo #(
    .WIDTH(sync_serial_pkg::CHAR_WIDTH),
    .DEPTH(sync_serial_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .clear_i(~port_enable),
    .push_i(fifo_push),
    .push_data_i(rx_char),
    .pop_i(rd_pop),
    .top_o(fifo_top),
    .empty_o(fifo_empty),
    .full_o(fifo_full)
  );

  // Receive flag stays set while unread characters remain.
  assign receive_complete_flag = ~fifo_empty;
  assign tx_event = interrupt_control_ff[sync_serial_pkg::INT_TRANSMIT_ENABLE] & transmit_buffer_empty_flag;
  assign rx_event = interrupt_control_ff[sync_serial_pkg::INT_RECEIVE_ENABLE] & receive_complete_flag;

  // Wake and interrupt requests are registered from the flags and enables.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wake_o <= 1'b0;
      irq_o <= 1'b0;
      rx_int_o <= 1'b0;
    end else if (ce_i) begin
      wake_o <= sleep_i & ((interrupt_control_ff[sync_serial_pkg::INT_PERIPHERAL_ENABLE] & tx_event)
        | rx_event);
      irq_o <= interrupt_control_ff[sync_serial_pkg::INT_GLOBAL_ENABLE]
        & interrupt_control_ff[sync_serial_pkg::INT_PERIPHERAL_ENABLE] & (tx_event | rx_event);
      rx_int_o <= rx_event;
    end
  end

endmodule : sync_serial_slave_port

`default_nettype wire

// ### verif/sync_serial_slave_port_checker.sv
`default_nettype none
module sync_serial_slave_port_checker (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sleep_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic shift_clock_pin_i,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_pin_oe_n_o,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe_n_o,
  input wire logic wake_o,
  input wire logic rx_int_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ck_q_ff;
  logic [3:0] rise_cnt_ff;
  // Counts cycles since the shift clock last rose, saturating at 15.
  always_ff @(posedge mclk_i) begin
    ck_q_ff <= shift_clock_pin_i;
    if (reset_i) begin
      rise_cnt_ff <= 4'hF;
    end else if (shift_clock_pin_i && !ck_q_ff) begin
      rise_cnt_ff <= 4'h0;
    end else if (rise_cnt_ff != 4'hF) begin
      rise_cnt_ff <= rise_cnt_ff + 4'h1;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // A waiting request and its answer one cycle later.
  sequence req_wait_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence ack_s;
    !avs_waitrequest_o;
  endsequence
  wait_one_a: assert property (req_wait_s |=> ack_s)
    else $error("bus request waited more than one cycle");
  first_wait_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("bus request answered without a wait state");
  idle_ready_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest high with no request");
  high_zero_a: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  clock_off_a: assert property (shift_clock_pin_oe_n_o && !shift_clock_pin_o)
    else $error("shift clock driver enabled");
  wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
    else $error("wake raised outside sleep");
  rx_wake_a: assert property (rx_int_o && $past(sleep_i) |-> wake_o)
    else $error("receive interrupt in sleep without wake");
  bit_hold_a: assert property ($changed(serial_data_pin_o) && !serial_data_pin_oe_n_o
    && $stable(serial_data_pin_oe_n_o) |-> rise_cnt_ff inside {[4'h1:4'h6]})
    else $error("transmit bit changed away from a leading edge");
endmodule : sync_serial_slave_port_checker
`default_nettype wire

// ### verif/serial_master_model.sv
`default_nettype none
module serial_master_model (
  output logic ck_o,
  output logic dat_o,
  input wire logic dat_i,
  output logic [8:0] got_o,
  output logic got_stb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The clock stands low between frames.
  initial begin
    ck_o = 1'b0;
    dat_o = 1'b0;
    got_o = 9'h000;
    got_stb_o = 1'b0;
  end
  // Clocks one character off the system clock edges, so no pin change races the slave's first flip-flop.
  task automatic xfer(input logic [8:0] d, input int n);
    got_o = 9'h000;
    #2;
    for (int i = 0; i < n; i++) begin
      ck_o = 1'b1;
      dat_o = d[i];
      #32 ck_o = 1'b0;
      #28 got_o[i] = dat_i;
      #4;
    end
    dat_o = ~dat_o; // A released line shows the inverse of its last value.
    got_stb_o = 1'b1;
    #8 got_stb_o = 1'b0;
  endtask : xfer
endmodule : serial_master_model
`default_nettype wire

// ### verif/sync_serial_slave_port_tb_top.sv
`default_nettype none
module sync_serial_slave_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sleep_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] rdata;
  logic wreq, ck, mst_dat, dut_dat, dut_oe_n, dat_w, wake, irq, rx_int, got_stb, pin_req = 1'b0;
  logic [8:0] got;
  logic [8:0] d [4];
  logic [31:0] rd_q [$];
  logic [8:0] ser_q [$];
  logic [3:0] pin_q [$];
  int fail_count = 0;
  int cmp_count = 0;
  // The data wire follows whichever party has its driver on.
  assign dat_w = dut_oe_n ? mst_dat : dut_dat;
  sync_serial_slave_port u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1), .sleep_i(sleep_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h1), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .shift_clock_pin_i(ck), .shift_clock_pin_o(), .shift_clock_pin_oe_n_o(),
    .serial_data_pin_i(dat_w), .serial_data_pin_o(dut_dat), .serial_data_pin_oe_n_o(dut_oe_n),
    .wake_o(wake), .irq_o(irq), .rx_int_o(rx_int));
  serial_master_model u_mst (.ck_o(ck), .dat_o(mst_dat), .dat_i(dat_w), .got_o(got), .got_stb_o(got_stb));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic note(input logic ok, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (!ok) begin
      fail_count++;
      $display("unexpected value at %0t ns: expected %h got %h", $time, e, g);
    end
  endtask : note
  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
    note(g === e, e, g);
  endtask : cmp_reg
  task automatic cmp_ser(input logic [8:0] e, input logic [8:0] g);
    note(g === e, {23'h0, e}, {23'h0, g});
  endtask : cmp_ser
  task automatic cmp_pin(input logic [3:0] e, input logic [3:0] g);
    note(g === e, {28'h0, e}, {28'h0, g});
  endtask : cmp_pin
  // Watches answers and compares each with the oldest note.
  always @(posedge mclk_i) begin
    if (avs_read_i && wreq === 1'b0 && rd_q.size() > 0) cmp_reg(rd_q.pop_front(), rdata);
    if (pin_req && pin_q.size() > 0) cmp_pin(pin_q.pop_front(), {dut_oe_n, wake, irq, rx_int});
  end
  always @(posedge got_stb) begin
    if (ser_q.size() > 0) cmp_ser(ser_q.pop_front(), got);
  end
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] v);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, v};
    avs_write_i <= 1'b1;
    do @(posedge mclk_i); while (wreq !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask : bus_wr
  task automatic bus_rd(input logic [4:0] a, input logic [7:0] e);
    rd_q.push_back({24'h000000, e});
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge mclk_i); while (wreq !== 1'b0);
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask : bus_rd
  task automatic pins(input logic [3:0] e);
    pin_q.push_back(e);
    pin_req <= 1'b1;
    @(posedge mclk_i);
    pin_req <= 1'b0;
    @(posedge mclk_i);
  endtask : pins
  task automatic send(input logic [8:0] v, input int n, input logic chk);
    if (chk) ser_q.push_back(v);
    u_mst.xfer(v, n);
    repeat (8) @(posedge mclk_i);
  endtask : send
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  // Reset values, unmapped place, sleep transmit, receive into overrun, eight-bit legs, port disable.
  initial begin
    void'($urandom(71263));
    for (int i = 0; i < 4; i++) d[i] = 9'($urandom());
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    bus_rd(sync_serial_pkg::ADDR_INTERRUPT_CONTROL, 8'h01);
    bus_rd(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'h00);
    bus_rd(sync_serial_pkg::ADDR_TX_HOLDING_DATA, 8'h00);
    bus_rd(5'h02, 8'h00);
    bus_wr(sync_serial_pkg::ADDR_BAUD_DIVISOR_LOW, d[3][7:0]);
    bus_rd(sync_serial_pkg::ADDR_BAUD_DIVISOR_LOW, d[3][7:0]);
    bus_wr(sync_serial_pkg::ADDR_TX_STATUS_CONTROL, 8'h71);
    bus_wr(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'h80);
    bus_wr(sync_serial_pkg::ADDR_INTERRUPT_CONTROL, 8'hD0);
    bus_wr(sync_serial_pkg::ADDR_TX_HOLDING_DATA, d[0][7:0]);
    bus_wr(sync_serial_pkg::ADDR_TX_HOLDING_DATA, d[1][7:0]);
    sleep_i <= 1'b1;
    bus_rd(sync_serial_pkg::ADDR_INTERRUPT_CONTROL, 8'hD0);
    pins(4'b0000);
    send({1'b1, d[0][7:0]}, 9, 1'b1);
    bus_rd(sync_serial_pkg::ADDR_INTERRUPT_CONTROL, 8'hD1);
    pins(4'b0110);
    send({1'b1, d[1][7:0]}, 9, 1'b1);
    bus_wr(sync_serial_pkg::ADDR_TX_STATUS_CONTROL, 8'h10);
    bus_wr(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'hF0);
    bus_wr(sync_serial_pkg::ADDR_INTERRUPT_CONTROL, 8'hE0);
    pins(4'b1000);
    send(d[0], 9, 1'b0);
    pins(4'b1111);
    send(d[1], 9, 1'b0);
    send(d[2], 9, 1'b0);
    bus_rd(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'hF2 | d[0][8]);
    bus_wr(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'hE0);
    bus_rd(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'hE0 | d[0][8]);
    bus_rd(sync_serial_pkg::ADDR_RX_DATA_FIFO_TOP, d[0][7:0]);
    bus_rd(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'hE0 | d[1][8]);
    bus_rd(sync_serial_pkg::ADDR_RX_DATA_FIFO_TOP, d[1][7:0]);
    bus_rd(sync_serial_pkg::ADDR_INTERRUPT_CONTROL, 8'hE1);
    bus_wr(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'hD0);
    send(d[3], 9, 1'b0);
    bus_rd(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'hD0 | d[3][8]);
    bus_rd(sync_serial_pkg::ADDR_RX_DATA_FIFO_TOP, d[3][7:0]);
    bus_wr(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'h90);
    send(d[2], 8, 1'b0);
    bus_rd(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'h90);
    bus_rd(sync_serial_pkg::ADDR_RX_DATA_FIFO_TOP, d[2][7:0]);
    bus_wr(sync_serial_pkg::ADDR_TX_STATUS_CONTROL, 8'h30);
    bus_wr(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'h80);
    bus_wr(sync_serial_pkg::ADDR_TX_HOLDING_DATA, d[3][7:0]);
    send({1'b0, d[3][7:0]}, 8, 1'b1);
    bus_wr(sync_serial_pkg::ADDR_RX_STATUS_CONTROL, 8'h00);
    pins(4'b1000);
    give_verdict();
  end
endmodule : sync_serial_slave_port_tb_top
bind sync_serial_slave_port sync_serial_slave_port_checker u_chk (.mclk_i, .reset_i, .sleep_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .shift_clock_pin_i, .shift_clock_pin_o,
  .shift_clock_pin_oe_n_o, .serial_data_pin_o, .serial_data_pin_oe_n_o, .wake_o, .rx_int_o);
`default_nettype wire
